// ---- rls_pkg.sv ----
// constants, types and helpers shared by both ends of the low-power scheduler
//
// Function
// - idle scan interval fixed at 0x1000 slots
// - scan window resets to 0x0100 slots
// - inquiry window set by command, nonzero min 0x0012
// - page window set by command, min 0x0012
// - zero inquiry window stops inquiry, page continues
// - sniff off after reset, device always awake
// - sniff wakes radio every programmed slot interval
// - sniff only when peer agrees, else active
// - host keeps sniff interval at most 0x7fff
// - bit 15 is deep flag, not interval
// - normal sleep housekeeping about 20 per second
// - deep sleep refreshes indicators once per second
// - serial character or cts rising edge wakes quickly
// - host raises cts, waits 5 ms, sends
// - each sniff wake listens for 8 slots
// - stay awake 1 second without activity, sleep
// - extra on/off duty cycle set by command
package rls_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // time base
  localparam int CLK_NS   = 100;
  localparam int SLOT_NS  = 625000;
  localparam int SLOT_CYC = (SLOT_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_MS  = 5;
  localparam int WAKE_CYC = WAKE_MS * 1000000 / CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // slot counts and reset values
  localparam logic [15:0] SCAN_INTERVAL = 16'h1000;
  localparam logic [15:0] SCAN_WIN_RST  = 16'h0100;
  localparam logic [15:0] SCAN_WIN_MIN  = 16'h0012;
  localparam logic [15:0] SNIFF_RST     = 16'h0000;
  localparam logic [15:0] DUTY_RST      = 16'h0000;
  localparam int          DEEP_BIT      = 15;
  localparam int          ACTIVE_MS     = 1000;
  localparam logic [15:0] ACTIVE_SLOTS  = 16'(ACTIVE_MS * 1000000 / SLOT_NS);
  localparam logic [15:0] LISTEN_SLOTS  = 16'h0008;
  localparam int          HK_MS         = 50;
  localparam logic [15:0] HK_SLOTS      = 16'(HK_MS * 1000000 / SLOT_NS);
  localparam int          LED_DEEP_MS   = 1000;
  localparam logic [15:0] LED_SLOTS     = 16'(LED_DEEP_MS * 1000000 / SLOT_NS);

  ////////////////////////////////////////////////////////////////////////////
  // host register offsets
  localparam logic [2:0] REG_INQ_WIN  = 3'h0;
  localparam logic [2:0] REG_PAGE_WIN = 3'h1;
  localparam logic [2:0] REG_SNIFF    = 3'h2;
  localparam logic [2:0] REG_DUTY     = 3'h3;
  localparam logic [2:0] REG_CHAR     = 3'h4;
  localparam logic [2:0] REG_STATUS   = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // commands on the link
  typedef enum logic [1:0]
  {
    RLS_CMD_INQ   = 2'h0,
    RLS_CMD_PAGE  = 2'h1,
    RLS_CMD_SNIFF = 2'h2,
    RLS_CMD_DUTY  = 2'h3
  } rls_cmd_t;

  // raise a short window to the minimum, zero kept only where allowed
  function automatic logic [15:0] rlsClampWin(input logic [15:0] win, input logic zeroOk);
    if (win == 16'h0000 && zeroOk)
      return 16'h0000;
    else if (win < SCAN_WIN_MIN)
      return SCAN_WIN_MIN;
    else
      return win;
  endfunction

endpackage

// ---- rls_if.sv ----
// link between host controller and radio module scheduler
`timescale 1ns/1ps
`default_nettype none
interface rls_if;
  import rls_pkg::*;
  logic           cmdValid;  // one-cycle command strobe
  rls_cmd_t       cmdCode;
  logic    [15:0] cmdData;
  logic           cts;       // host clear-to-send level
  logic           rxChar;    // one-cycle serial character arrival
  logic           devAwake;  // device awake level

  modport device (input cmdValid, cmdCode, cmdData, cts, rxChar, output devAwake);
  modport host (output cmdValid, cmdCode, cmdData, cts, rxChar, input devAwake);
endinterface
`default_nettype wire

// ---- rls_device.sv ----
// scheduler end inside the radio module: scan duty, sniff sleep and wake
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rls_device
#(
  parameter int SLOT_CYCLES = rls_pkg::SLOT_CYC
)
(
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  // link to host
  rls_if.device       link,
  // radio state
  input  wire logic   connected,
  input  wire logic   peerSniffOk,
  input  wire logic   radioXfer,
  // radio and housekeeping controls
  output logic        radioOn,
  output logic        inqScan,
  output logic        pageScan,
  output logic        housekeep,
  output logic        ledTick,
  output logic        deepSleep,
  output logic        awake
);
  import rls_pkg::*;

  typedef enum logic [1:0]
  {
    ST_AWAKE  = 2'b00,
    ST_SLEEP  = 2'b01,
    ST_LISTEN = 2'b11
  } rls_dstate_t;

  generate
    if (SLOT_CYCLES < 1 || SLOT_CYCLES > 65535)
    begin : gBadSlot
      $error("slot divider out of range");
    end
  endgenerate

  logic [15:0] slotCnt;
  logic        slotTick;
  logic [15:0] inqWin;
  logic [15:0] pageWin;
  logic [15:0] sniffWord;
  logic [15:0] dutyWord;
  logic [7:0]  dutyCnt;
  logic        dutyOff;
  logic [15:0] scanCnt;
  logic [15:0] tmr;
  logic [15:0] hkCnt;
  logic [15:0] ledCnt;
  logic        ctsPrev;
  rls_dstate_t st;
  logic [15:0] sniffInt;
  logic        sniffOn;
  logic        wakeEv;
  logic        activity;
  logic        dutyGate;
  logic        next_inq;
  logic        next_page;
  logic        deepAsleep;
  logic        hkWrap;
  logic        ledWrap;

  ////////////////////////////////////////////////////////////////////////////
  // slot time base
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      slotCnt  <= 16'h0000;
      slotTick <= 1'b0;
    end
    else if (slotCnt == 16'(SLOT_CYCLES - 1))
    begin
      slotCnt  <= 16'h0000;
      slotTick <= 1'b1;
    end
    else
    begin
      slotCnt  <= slotCnt + 16'h0001;
      slotTick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings written by host commands
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      inqWin    <= SCAN_WIN_RST;
      pageWin   <= SCAN_WIN_RST;
      sniffWord <= SNIFF_RST;
      dutyWord  <= DUTY_RST;
    end
    else if (link.cmdValid)
    begin
      unique case (link.cmdCode)
        RLS_CMD_INQ:   inqWin    <= rlsClampWin(link.cmdData, 1'b1);
        RLS_CMD_PAGE:  pageWin   <= rlsClampWin(link.cmdData, 1'b0);
        RLS_CMD_SNIFF: sniffWord <= link.cmdData;
        RLS_CMD_DUTY:  dutyWord  <= link.cmdData;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // extra duty cycle: high byte on slots, low byte off slots, zero disables
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || dutyWord == 16'h0000)
    begin
      dutyCnt <= 8'h00;
      dutyOff <= 1'b0;
    end
    else if (slotTick)
    begin
      if (dutyCnt + 8'h01 >= (dutyOff ? dutyWord[7:0] : dutyWord[15:8]))
      begin
        dutyCnt <= 8'h00;
        dutyOff <= !dutyOff;
      end
      else
        dutyCnt <= dutyCnt + 8'h01;
    end
  end

  assign dutyGate = (dutyWord == 16'h0000) || !dutyOff;

  ////////////////////////////////////////////////////////////////////////////
  // idle scan interval and windows
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      scanCnt <= 16'h0000;
    else if (slotTick)
      scanCnt <= (scanCnt == SCAN_INTERVAL - 16'h0001) ? 16'h0000 : scanCnt + 16'h0001;
  end

  // inquiry stops at zero window while page goes on
  assign next_inq  = !connected && inqWin != 16'h0000 && scanCnt < inqWin && dutyGate;
  assign next_page = !connected && scanCnt < pageWin && dutyGate;

  ////////////////////////////////////////////////////////////////////////////
  // wake sources and sniff qualification
  assign sniffInt = {1'b0, sniffWord[14:0]};
  assign sniffOn  = connected && peerSniffOk && sniffInt != 16'h0000;
  assign wakeEv   = link.rxChar || (link.cts && !ctsPrev);
  assign activity = link.rxChar || radioXfer;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      ctsPrev <= 1'b0;
    else
      ctsPrev <= link.cts;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sniff sleep sequencer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !sniffOn)
    begin
      st  <= ST_AWAKE;
      tmr <= 16'h0000;
    end
    else
    begin
      unique case (st)
        ST_AWAKE:
        begin
          if (activity || wakeEv)
            tmr <= 16'h0000;
          else if (slotTick)
          begin
            if (tmr == ACTIVE_SLOTS - 16'h0001)
            begin
              st  <= ST_SLEEP;
              tmr <= 16'h0000;
            end
            else
              tmr <= tmr + 16'h0001;
          end
        end
        ST_SLEEP:
        begin
          if (wakeEv || radioXfer)
          begin
            st  <= ST_AWAKE;
            tmr <= 16'h0000;
          end
          else if (slotTick)
          begin
            if (tmr + 16'h0001 >= sniffInt)
            begin
              st  <= ST_LISTEN;
              tmr <= 16'h0000;
            end
            else
              tmr <= tmr + 16'h0001;
          end
        end
        ST_LISTEN:
        begin
          if (wakeEv || radioXfer)
          begin
            st  <= ST_AWAKE;
            tmr <= 16'h0000;
          end
          else if (slotTick)
          begin
            if (tmr == LISTEN_SLOTS - 16'h0001)
            begin
              st  <= ST_SLEEP;
              tmr <= 16'h0000;
            end
            else
              tmr <= tmr + 16'h0001;
          end
        end
        default:
        begin
          st  <= ST_AWAKE;
          tmr <= 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // housekeeping and indicator ticks
  assign deepAsleep = st != ST_AWAKE && sniffWord[DEEP_BIT];
  assign hkWrap     = slotTick && hkCnt == HK_SLOTS - 16'h0001;
  assign ledWrap    = slotTick && ledCnt == LED_SLOTS - 16'h0001;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      hkCnt  <= 16'h0000;
      ledCnt <= 16'h0000;
    end
    else if (slotTick)
    begin
      hkCnt  <= hkWrap ? 16'h0000 : hkCnt + 16'h0001;
      ledCnt <= ledWrap ? 16'h0000 : ledCnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      radioOn   <= 1'b0;
      inqScan   <= 1'b0;
      pageScan  <= 1'b0;
      housekeep <= 1'b0;
      ledTick   <= 1'b0;
      deepSleep <= 1'b0;
      awake     <= 1'b1;
    end
    else
    begin
      inqScan   <= next_inq;
      pageScan  <= next_page;
      radioOn   <= connected ? (st != ST_SLEEP) : (next_inq || next_page);
      housekeep <= hkWrap && !deepAsleep;
      ledTick   <= deepAsleep ? ledWrap : hkWrap;
      deepSleep <= deepAsleep;
      awake     <= st == ST_AWAKE;
    end
  end

  assign link.devAwake = awake;

endmodule
`default_nettype wire

// ---- rls_host.sv ----
// host controller end: register port, commands and safe wake before sending
`timescale 1ns/1ps
`default_nettype none
module rls_host
#(
  parameter int WAKE_CYCLES = rls_pkg::WAKE_CYC
)
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // software register port
  input  wire logic [2:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  // link to module
  rls_if.host              link
);
  import rls_pkg::*;

  typedef enum logic [1:0]
  {
    H_IDLE = 2'b00,
    H_WAIT = 2'b01,
    H_SEND = 2'b11
  } rls_hstate_t;

  generate
    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535)
    begin : gBadWake
      $error("wake wait out of range");
    end
  endgenerate

  rls_hstate_t hst;
  logic [15:0] waitCnt;
  logic [15:0] shadow [4];
  logic [15:0] wrVal;

  ////////////////////////////////////////////////////////////////////////////
  // short window writes raised to the minimum, zero inquiry kept, sniff bit 15 stays the deep flag
  always_comb
  begin
    wrVal = regWdata;
    if (regAddr == REG_INQ_WIN)
      wrVal = rlsClampWin(regWdata, 1'b1);
    else if (regAddr == REG_PAGE_WIN)
      wrVal = rlsClampWin(regWdata, 1'b0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // command issue and shadow copies
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      link.cmdValid <= 1'b0;
      link.cmdCode  <= RLS_CMD_INQ;
      link.cmdData  <= 16'h0000;
      shadow[0]     <= SCAN_WIN_RST;
      shadow[1]     <= SCAN_WIN_RST;
      shadow[2]     <= SNIFF_RST;
      shadow[3]     <= DUTY_RST;
    end
    else
    begin
      link.cmdValid <= regWr && !regAddr[2];
      if (regWr && !regAddr[2])
      begin
        link.cmdCode           <= rls_cmd_t'(regAddr[1:0]);
        link.cmdData           <= wrVal;
        shadow[regAddr[1:0]]   <= wrVal;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // character send: raise cts, wait, then send
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      hst         <= H_IDLE;
      waitCnt     <= 16'h0000;
      link.cts    <= 1'b0;
      link.rxChar <= 1'b0;
    end
    else
    begin
      link.rxChar <= 1'b0;
      unique case (hst)
        H_IDLE:
        begin
          if (regWr && regAddr == REG_CHAR)
          begin
            hst      <= H_WAIT;
            link.cts <= 1'b1;
            waitCnt  <= 16'h0000;
          end
        end
        H_WAIT:
        begin
          if (waitCnt == 16'(WAKE_CYCLES - 1))
          begin
            hst         <= H_SEND;
            link.rxChar <= 1'b1;
          end
          else
            waitCnt <= waitCnt + 16'h0001;
        end
        H_SEND:
        begin
          hst      <= H_IDLE;
          link.cts <= 1'b0;
        end
        default:
        begin
          hst      <= H_IDLE;
          link.cts <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      regRdata <= 16'h0000;
    else if (regRd)
    begin
      if (!regAddr[2])
        regRdata <= shadow[regAddr[1:0]];
      else if (regAddr == REG_STATUS)
        regRdata <= {14'h0000, hst != H_IDLE, link.devAwake};
      else
        regRdata <= 16'h0000;
    end
    else
      regRdata <= 16'h0000;
  end

endmodule
`default_nettype wire

// ---- rls_asserts.sv ----
// concurrent checks on the scheduler link and device outputs
`timescale 1ns/1ps
`default_nettype none
module rls_asserts
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst_n,
  // link signals
  input wire logic              cmdValid,
  input wire rls_pkg::rls_cmd_t cmdCode,
  input wire logic [15:0]       cmdData,
  input wire logic              cts,
  input wire logic              rxChar,
  input wire logic              devAwake,
  // device side
  input wire logic              connected,
  input wire logic              peerSniffOk,
  input wire logic              inqScan,
  input wire logic              pageScan,
  input wire logic              radioOn,
  input wire logic              housekeep,
  input wire logic              deepSleep
);
  import rls_pkg::*;
  logic [15:0] sniffWord;
  logic        inqZero;

  ////////////////////////////////////////////////////////////////////////////
  // follow the settings carried by link commands
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sniffWord <= 16'h0000;
      inqZero   <= 1'b0;
    end
    else if (cmdValid && cmdCode == RLS_CMD_SNIFF)
      sniffWord <= cmdData;
    else if (cmdValid && cmdCode == RLS_CMD_INQ)
      inqZero <= (cmdData == 16'h0000);
  end

  ////////////////////////////////////////////////////////////////////////////
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence ctsRise;
    $rose(cts);
  endsequence
  sequence hostWait;
    !rxChar [*8];
  endsequence

  rx_wake_a: assert property (rxChar |-> ##[1:3] devAwake)
    else $error("serial char did not wake the device");
  cts_wake_a: assert property (ctsRise |-> ##[1:3] devAwake)
    else $error("cts rise did not wake the device");
  cts_wait_a: assert property (ctsRise |-> hostWait)
    else $error("host sent before the wake delay");
  no_sniff_a: assert property ((!connected || !peerSniffOk || sniffWord[14:0] == 15'h0000) [*3]
    |-> devAwake)
    else $error("device asleep without agreed sniff");
  inq_off_a: assert property (inqZero [*3] |-> !inqScan)
    else $error("inquiry scan with zero window");
  conn_scan_a: assert property (connected [*3] |-> !inqScan && !pageScan)
    else $error("idle scan while connected");
  deep_flag_a: assert property (!sniffWord[15] [*3] |-> !deepSleep)
    else $error("deep sleep without deep flag");
  deep_hk_a: assert property (deepSleep [*2] |-> !housekeep)
    else $error("housekeeping during deep sleep");
  radio_conn_a: assert property ((connected && devAwake) [*2] |-> radioOn)
    else $error("radio off while awake and connected");
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench joining host controller and device scheduler
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rls_pkg::*;
  localparam int SC = 4;
  localparam int WC = 8;
  logic        clk_sys;
  logic        rst_n = 1'b0;
  logic [2:0]  regAddr = 3'h0;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdata;
  logic        connected = 1'b0;
  logic        peerSniffOk = 1'b0;
  logic        radioXfer = 1'b0;
  logic        radioOn, inqScan, pageScan, housekeep, ledTick, deepSleep, awake;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  integer      seed = 32'hd3402137;
  int          mInq = 'h100;
  int          mPage = 'h100;

  rls_if lnk();
  rls_host #(.WAKE_CYCLES(WC)) rls_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .link(lnk));
  rls_device #(.SLOT_CYCLES(SC)) rls_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(lnk),
    .connected(connected), .peerSniffOk(peerSniffOk), .radioXfer(radioXfer), .radioOn(radioOn),
    .inqScan(inqScan), .pageScan(pageScan), .housekeep(housekeep), .ledTick(ledTick),
    .deepSleep(deepSleep), .awake(awake));
  rls_asserts rls_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n), .cmdValid(lnk.cmdValid),
    .cmdCode(lnk.cmdCode), .cmdData(lnk.cmdData), .cts(lnk.cts), .rxChar(lnk.rxChar),
    .devAwake(lnk.devAwake), .connected(connected), .peerSniffOk(peerSniffOk),
    .inqScan(inqScan), .pageScan(pageScan), .radioOn(radioOn), .housekeep(housekeep),
    .deepSleep(deepSleep));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang limit
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      bad_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    d = regRdata;
  endtask
  function automatic int clampW(int w, bit zeroOk);
    if (w == 0 && zeroOk)
      return 0;
    return (w < 'h12) ? 'h12 : w;
  endfunction
  task automatic setWin(input logic [2:0] a, input int w);
    logic [15:0] d;
    wr(a, w[15:0]);
    if (a == 3'h0)
      mInq = clampW(w, 1'b1);
    else
      mPage = clampW(w, 1'b0);
    rd(a, d);
    chk("window", d, (a == 3'h0) ? mInq : mPage);
  endtask
  task automatic scanCount(output int ni, output int np);
    ni = 0;
    np = 0;
    repeat (8) @(negedge clk_sys);
    repeat ('h1000 * SC)
    begin
      @(negedge clk_sys);
      ni += int'(inqScan === 1'b1);
      np += int'(pageScan === 1'b1);
    end
  endtask
  // wait for awake (useRadio low) or radioOn (useRadio high) to reach a level
  task automatic waitLvl(input bit useRadio, input logic v, output int n);
    n = 0;
    while ((useRadio ? radioOn : awake) !== v && n < 20000)
    begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  // count housekeeping and indicator pulses over a number of cycles
  task automatic tickCount(input int len, output int nh, output int nl);
    nh = 0;
    nl = 0;
    repeat (len)
    begin
      @(negedge clk_sys);
      nh += int'(housekeep === 1'b1);
      nl += int'(ledTick === 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    int          ni, np, n, v;
    logic [15:0] d;
    int          vals[8] = '{0, 5, 'h12, 'h200, 0, 'h11, 'h13, 0};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("awake", awake, 1'b1);
    chk("radioOn", radioOn, 1'b0);
    rd(3'h0, d);
    chk("inq reset", d, 16'h0100);
    rd(3'h1, d);
    chk("page reset", d, 16'h0100);
    scanCount(ni, np);
    chk("inq slots", ni, 'h100 * SC);
    chk("page slots", np, 'h100 * SC);
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 7) ? ('h12 + ($random(seed) & 'h3ff)) : vals[i];
      setWin((i < 4) ? 3'h0 : 3'h1, v);
    end
    setWin(3'h0, 0);
    scanCount(ni, np);
    chk("inq off", ni, 0);
    chk("page on", np, mPage * SC);
    // one slot on, one slot off halves an even page window
    setWin(3'h1, 'h200);
    wr(3'h3, 16'h0101);
    scanCount(ni, np);
    chk("duty page", np, mPage / 2 * SC);
    rd(3'h6, d);
    chk("unmapped", d, 16'h0000);
    rd(3'h5, d);
    chk("status", d, 16'h0001);
    wr(3'h3, 16'h1234);
    rd(3'h3, d);
    chk("duty", d, 16'h1234);
    @(posedge clk_sys);
    connected   <= 1'b1;
    peerSniffOk <= 1'b1;
    wr(3'h2, 16'h8010);
    rd(3'h2, d);
    chk("sniff word", d, 16'h8010);
    // a radio exchange half way restarts the one second idle count
    repeat (800 * SC) @(negedge clk_sys);
    chk("awake mid", awake, 1'b1);
    @(posedge clk_sys);
    radioXfer <= 1'b1;
    @(posedge clk_sys);
    radioXfer <= 1'b0;
    waitLvl(1'b0, 1'b0, n);
    chk("idle time", n >= 1597 * SC && n <= 1602 * SC, 1'b1);
    @(negedge clk_sys);
    chk("deep", deepSleep, 1'b1);
    waitLvl(1'b1, 1'b1, n);
    chk("sniff interval", n >= 15 * SC && n <= 17 * SC, 1'b1);
    waitLvl(1'b1, 1'b0, n);
    chk("listen time", n >= 7 * SC && n <= 9 * SC, 1'b1);
    // deep sleep: no housekeeping, one indicator refresh per 1600 slots
    tickCount(1600 * SC, ni, np);
    chk("deep housekeep", ni, 0);
    chk("deep led", np, 1);
    wr(3'h4, 16'h0041);
    waitLvl(1'b0, 1'b1, n);
    chk("char wake", n <= WC + 6, 1'b1);
    @(posedge clk_sys);
    peerSniffOk <= 1'b0;
    // awake: twenty housekeeping and indicator pulses per 1600 slots
    tickCount(1600 * SC, ni, np);
    chk("housekeep", ni, 20);
    chk("led", np, 20);
    repeat (100 * SC) @(negedge clk_sys);
    chk("no agreement", awake, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
